// ==== design/addr_line_decode.sv ====
/*
  Decodes the address-count field into one enable per address line 23..0.
  Assumes lines 0 and 1 are handled elsewhere; their outputs stay low.
*/
`timescale 1ns/1ps
module addr_line_decode
(
  // Field in
  input wire logic [2:0] count_i,
  // Per-line enables
  output logic [pin_select_pkg::addr_lines-1:0] enable_o
);
  genvar g;
  generate
    for (g = 0; g < pin_select_pkg::addr_lines; g++)
    begin : g_line
      always_comb
      begin
        enable_o[g] = 1'b0;
        if (g >= 2 && count_i != pin_select_pkg::addr_cnt_none)
          enable_o[g] = (5'(g) <= pin_select_pkg::addr_top[count_i - 3'h1]);
      end
    end
  endgenerate
endmodule // addr_line_decode

// ==== design/bus_pin_function_select.sv ====
/*
  Bus pin function select register and its pin routing decode.
  Assumes a classic Wishbone master on clk_i, and boot_mode_pins_i from
  package pins (synchronised here). Direction bits come from a GPIO block.
*/
// Function
// - Port direction bit applies only to pins in general-purpose function.
// - Bit 3 routes port 1 pins 25..16 to the trace port.
// - Bus field 5:4 enables data lanes, strobes and byte lanes by width.
// - Bit 8 selects port pin 3.27 or the write-enable strobe.
// - Bit 11 selects port pin 3.26 or chip select one.
// - Bits 15:14 select pin 3.25 or chip select two; 1x reserved.
// - Bits 17:16 select pin 3.24 or chip select three; 1x reserved.
// - Bit 13 picks clock output on pin 3.23 unless address count is 111.
// - Outside 32-bit bus, bits 20..22 pick reserved or analog inputs four, five.
// - Bit 23 selects address line 0; resets 1 only when boot pins are 00.
// - Bit 24 selects address line 1; resets to upper boot pin.
// - Bits 27:25 set how many upper address lines are enabled.
// - Address count resets 000 for boot pins 11, else 111.
`timescale 1ns/1ps
module bus_pin_function_select
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Boot straps
  input wire logic [1:0] boot_mode_pins_i,
  // Direction from the port direction register, per pin
  input wire logic [31:0] port_direction_register_p1_i,
  input wire logic [31:0] port_direction_register_p2_i,
  input wire logic [31:0] port_direction_register_p3_i,
  // Function selected, 1 = alternate function
  output logic debug_port_en_o,
  output logic trace_port_en_o,
  output logic [31:0] data_lane_en_o,
  output logic chip_select_zero_en_o,
  output logic output_enable_en_o,
  output logic byte_lane_zero_en_o,
  output logic byte_lane_one_en_o,
  output logic byte_lane_two_en_o,
  output logic byte_lane_three_en_o,
  output logic write_enable_en_o,
  output logic chip_select_one_en_o,
  output logic chip_select_two_en_o,
  output logic chip_select_three_en_o,
  output logic clock_output_pin_en_o,
  output logic p2_hi_reserved_en_o,
  output logic analog_input_four_en_o,
  output logic analog_input_five_en_o,
  output logic [23:0] upper_address_lines_en_o,
  // Effective direction seen by the pads, 1 = output
  output logic [31:0] p1_dir_o,
  output logic [31:0] p2_dir_o,
  output logic [31:0] p3_dir_o
);
  typedef struct packed
  {
    logic [1:0] boot_meta;
    logic [1:0] boot_sync;
    logic strap_done;
    logic [31:0] sel_reg;
    logic [31:0] dat;
    logic ack;
    logic err;
    logic debug_en;
    logic trace_en;
    logic [31:0] data_en;
    logic cs0_en;
    logic oe_en;
    logic [3:0] bls_en;
    logic we_en;
    logic cs1_en;
    logic cs2_en;
    logic cs3_en;
    logic clk_en;
    logic p2res_en;
    logic analog_input_four_en;
    logic analog_input_five_en;
    logic [23:0] addr_en;
    logic [31:0] p1_dir;
    logic [31:0] p2_dir;
    logic [31:0] p3_dir;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic [23:0] addr_dec;
  logic [31:0] p1_alt;
  logic [31:0] p2_alt;
  logic [31:0] p3_alt;
  logic [31:0] p1_auto;
  logic [31:0] p2_auto;
  logic [31:0] p3_auto;
  logic [31:0] wmask;
  logic [1:0] bus;
  logic hit;
  logic [31:0] r;
  logic lane_low;
  logic lane_mid;
  logic lane_high;
  logic strap_addr0;
  logic strap_addr1;
  logic [2:0] strap_cnt;
  logic [31:0] p1_eff;
  logic [31:0] p2_eff;
  logic [31:0] p3_eff;

  addr_line_decode u_addr_decode
  (
    .count_i(cur.sel_reg[pin_select_pkg::addr_cnt_lo +: 3]),
    .enable_o(addr_dec)
  );

  assign r = cur.sel_reg;
  assign bus = r[pin_select_pkg::bus_lo +: 2];
  assign hit = adr_i[31:2] == pin_select_pkg::sel_reg_addr[31:2];
  // One mask byte per lane; a disabled lane keeps its old bits
  genvar l;
  generate
    for (l = 0; l < 4; l++)
    begin : g_lane
      assign wmask[8*l +: 8] = {8{sel_i[l]}} & pin_select_pkg::writable_mask[8*l +: 8];
    end
  endgenerate

  // Alternate-function direction: memory strobes and address are outputs,
  // data lanes follow the memory side, modelled as input when idle.
  always_comb
  begin
    p1_alt = 32'h0;
    p2_alt = 32'h0;
    p3_alt = 32'h0;
    p1_auto = 32'h0;
    p2_auto = 32'h0;
    p3_auto = 32'h0;
    p1_alt[31:26] = {6{cur.debug_en}};
    p1_alt[25:16] = {10{cur.trace_en}};
    p1_auto[25:16] = {10{cur.trace_en}};
    p1_alt[0] = cur.cs0_en;
    p1_auto[0] = cur.cs0_en;
    p1_alt[1] = cur.oe_en;
    p1_auto[1] = cur.oe_en;
    p2_alt = cur.data_en;
    p2_alt[29:28] = cur.data_en[29:28] | {2{cur.p2res_en}};
    p2_alt[30] = cur.data_en[30] | cur.analog_input_four_en;
    p2_alt[31] = cur.data_en[31] | cur.analog_input_five_en;
    p3_alt[31] = cur.bls_en[0];
    p3_alt[30] = cur.bls_en[1];
    p3_alt[29] = cur.bls_en[2];
    p3_alt[28] = cur.bls_en[3];
    p3_alt[27] = cur.we_en;
    p3_alt[26] = cur.cs1_en;
    p3_alt[25] = cur.cs2_en;
    p3_alt[24] = cur.cs3_en;
    p3_alt[23:0] = cur.addr_en;
    p3_alt[23] = cur.addr_en[23] | cur.clk_en;
    p3_auto[31:24] = p3_alt[31:24];
    p3_auto[23:0] = p3_alt[23:0];
  end

  // Width decode; 00 still gives the narrow bus
  always_comb
  begin
    case (bus)
      pin_select_pkg::bus_port_only:
      begin
        lane_low = 1'b0;
        lane_mid = 1'b0;
        lane_high = 1'b0;
      end
      pin_select_pkg::bus_wide:
      begin
        lane_low = 1'b1;
        lane_mid = 1'b1;
        lane_high = 1'b1;
      end
      pin_select_pkg::bus_half:
      begin
        lane_low = 1'b1;
        lane_mid = 1'b1;
        lane_high = 1'b0;
      end
      default:
      begin
        lane_low = 1'b1;
        lane_mid = 1'b0;
        lane_high = 1'b0;
      end
    endcase
  end

  // Straps come only from the second synchroniser stage
  always_comb
  begin
    case (cur.boot_sync)
      pin_select_pkg::boot_zero:
      begin
        strap_addr0 = 1'b1;
        strap_addr1 = 1'b0;
        strap_cnt = pin_select_pkg::addr_cnt_full;
      end
      pin_select_pkg::boot_ones:
      begin
        strap_addr0 = 1'b0;
        strap_addr1 = 1'b1;
        strap_cnt = pin_select_pkg::addr_cnt_none;
      end
      default:
      begin
        strap_addr0 = 1'b0;
        strap_addr1 = cur.boot_sync[1];
        strap_cnt = pin_select_pkg::addr_cnt_full;
      end
    endcase
  end

  // General-purpose pins take the port bit; alternate ones their own direction
  genvar b;
  generate
    for (b = 0; b < 32; b++)
    begin : g_dir
      always_comb
      begin
        p1_eff[b] = p1_alt[b] ? p1_auto[b] : port_direction_register_p1_i[b];
        p2_eff[b] = p2_alt[b] ? p2_auto[b] : port_direction_register_p2_i[b];
        p3_eff[b] = p3_alt[b] ? p3_auto[b] : port_direction_register_p3_i[b];
      end
    end
  endgenerate

  always_comb
  begin
    next_cur = cur;
    next_cur.boot_meta = boot_mode_pins_i;
    next_cur.boot_sync = cur.boot_meta;
    next_cur.ack = 1'b0;
    next_cur.err = 1'b0;
    if (!cur.strap_done)
    begin
      // Straps caught after release, once the synchroniser has filled
      next_cur.strap_done = 1'b1;
      next_cur.sel_reg[pin_select_pkg::bit_addr0] = strap_addr0;
      next_cur.sel_reg[pin_select_pkg::bit_addr1] = strap_addr1;
      next_cur.sel_reg[pin_select_pkg::addr_cnt_lo +: 3] = strap_cnt;
    end
    else if (cyc_i && stb_i && !cur.ack && !cur.err)
    begin
      if (hit)
      begin
        next_cur.ack = 1'b1;
        if (we_i)
          next_cur.sel_reg = (r & ~wmask) | (dat_i & wmask);
        next_cur.dat = r & pin_select_pkg::writable_mask;
      end
      else
      begin
        next_cur.err = 1'b1;
        next_cur.dat = 32'h0;
      end
    end
    // Function decode, one cycle behind the register
    next_cur.debug_en = r[pin_select_pkg::bit_debug];
    next_cur.trace_en = r[pin_select_pkg::bit_trace];
    next_cur.data_en = 32'h0;
    next_cur.data_en[7:0] = {8{lane_low}};
    next_cur.data_en[15:8] = {8{lane_mid}};
    next_cur.data_en[31:16] = {16{lane_high}};
    next_cur.cs0_en = lane_low;
    next_cur.oe_en = lane_low;
    next_cur.bls_en[0] = lane_low;
    next_cur.bls_en[1] = lane_mid;
    next_cur.bls_en[3:2] = {2{lane_high}};
    next_cur.we_en = r[pin_select_pkg::bit_we];
    next_cur.cs1_en = r[pin_select_pkg::bit_cs1];
    // Reserved codes 1x leave the pin as a port pin
    next_cur.cs2_en = r[pin_select_pkg::cs2_lo +: 2] == pin_select_pkg::cs_enabled;
    next_cur.cs3_en = r[pin_select_pkg::cs3_lo +: 2] == pin_select_pkg::cs_enabled;
    next_cur.clk_en = r[pin_select_pkg::bit_clkout] &&
      r[pin_select_pkg::addr_cnt_lo +: 3] != pin_select_pkg::addr_cnt_full;
    next_cur.p2res_en = bus != pin_select_pkg::bus_wide && r[pin_select_pkg::bit_p2_hi_res];
    next_cur.analog_input_four_en = bus != pin_select_pkg::bus_wide && r[pin_select_pkg::bit_analog_input_four];
    next_cur.analog_input_five_en = bus != pin_select_pkg::bus_wide && r[pin_select_pkg::bit_analog_input_five];
    next_cur.addr_en = addr_dec;
    next_cur.addr_en[0] = r[pin_select_pkg::bit_addr0];
    next_cur.addr_en[1] = r[pin_select_pkg::bit_addr1];
    // Port direction honoured only for general-purpose pins
    next_cur.p1_dir = p1_eff;
    next_cur.p2_dir = p2_eff;
    next_cur.p3_dir = p3_eff;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
      cur.sel_reg <= pin_select_pkg::reset_base;
      // Synchroniser runs through reset so the straps have settled at release
      cur.boot_meta <= next_cur.boot_meta;
      cur.boot_sync <= next_cur.boot_sync;
    end
    else
      cur <= next_cur;
  end

  assign dat_o = cur.dat;
  assign ack_o = cur.ack;
  assign err_o = cur.err;
  assign debug_port_en_o = cur.debug_en;
  assign trace_port_en_o = cur.trace_en;
  assign data_lane_en_o = cur.data_en;
  assign chip_select_zero_en_o = cur.cs0_en;
  assign output_enable_en_o = cur.oe_en;
  assign byte_lane_zero_en_o = cur.bls_en[0];
  assign byte_lane_one_en_o = cur.bls_en[1];
  assign byte_lane_two_en_o = cur.bls_en[2];
  assign byte_lane_three_en_o = cur.bls_en[3];
  assign write_enable_en_o = cur.we_en;
  assign chip_select_one_en_o = cur.cs1_en;
  assign chip_select_two_en_o = cur.cs2_en;
  assign chip_select_three_en_o = cur.cs3_en;
  assign clock_output_pin_en_o = cur.clk_en;
  assign p2_hi_reserved_en_o = cur.p2res_en;
  assign analog_input_four_en_o = cur.analog_input_four_en;
  assign analog_input_five_en_o = cur.analog_input_five_en;
  assign upper_address_lines_en_o = cur.addr_en;
  assign p1_dir_o = cur.p1_dir;
  assign p2_dir_o = cur.p2_dir;
  assign p3_dir_o = cur.p3_dir;
endmodule // bus_pin_function_select

// ==== inc/pin_select_pkg.sv ====
/*
  Package for the bus pin function select block: register offset, field
  positions, reset values and encodings.
  Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
package pin_select_pkg;
  localparam logic [31:0] sel_reg_addr = 32'he002c014;
  localparam logic [31:0] writable_mask = 32'h0ff3e93c;
  localparam int bit_debug = 2;
  localparam int bit_trace = 3;
  localparam int bus_lo = 4;
  localparam int bit_we = 8;
  localparam int bit_cs1 = 11;
  localparam int bit_clkout = 13;
  localparam int cs2_lo = 14;
  localparam int cs3_lo = 16;
  localparam int bit_p2_hi_res = 20;
  localparam int bit_analog_input_four = 21;
  localparam int bit_analog_input_five = 22;
  localparam int bit_addr0 = 23;
  localparam int bit_addr1 = 24;
  localparam int addr_cnt_lo = 25;
  localparam logic [31:0] reset_base = 32'h00600000;
  localparam logic [1:0] bus_port_only = 2'h3;
  localparam logic [1:0] bus_wide = 2'h2;
  localparam logic [1:0] bus_half = 2'h1;
  localparam logic [1:0] cs_enabled = 2'h1;
  localparam logic [1:0] boot_zero = 2'h0;
  localparam logic [1:0] boot_ones = 2'h3;
  localparam logic [2:0] addr_cnt_none = 3'h0;
  localparam logic [2:0] addr_cnt_full = 3'h7;
  localparam int addr_lines = 24;
  localparam int addr_groups = 7;
  // Highest address line enabled for field values 1..7
  localparam logic [4:0] addr_top [addr_groups] =
    '{5'h03, 5'h05, 5'h07, 5'h0b, 5'h0f, 5'h13, 5'h17};
endpackage

// ==== testbench/bus_pin_function_select_tb_top.sv ====
/* Bench for the bus pin function select block.
   Assumes the board model drives straps and direction bits. */
`timescale 1ns/1ps
module bus_pin_function_select_tb_top;
  localparam logic [31:0] reg_a = pin_select_pkg::sel_reg_addr;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, rd;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] bsel = 4'hf;
  logic [1:0] strap = 2'h0, boot_mode_pins_i;
  logic [31:0] dat_o, data_lane_en_o, p1_dir_o, p2_dir_o, p3_dir_o;
  logic [31:0] port_direction_register_p1_i, port_direction_register_p2_i;
  logic [31:0] port_direction_register_p3_i;
  logic ack_o, err_o, got_err, debug_port_en_o, trace_port_en_o, chip_select_zero_en_o;
  logic output_enable_en_o, byte_lane_zero_en_o, byte_lane_one_en_o, byte_lane_two_en_o;
  logic byte_lane_three_en_o, write_enable_en_o, chip_select_one_en_o, chip_select_two_en_o;
  logic chip_select_three_en_o, clock_output_pin_en_o, p2_hi_reserved_en_o;
  logic analog_input_four_en_o, analog_input_five_en_o;
  logic [23:0] upper_address_lines_en_o;
  logic [31:0] lane_x [4] = '{32'hff, 32'hffff, 32'hffffffff, 32'h0};
  logic [31:0] pin_x [4] = '{32'h3800, 32'h3c00, 32'h3f00, 32'h0};
  logic [21:0] am [8] = '{22'h0, 22'h3, 22'hf, 22'h3f, 22'h3ff, 22'h3fff, 22'h3ffff, 22'h3fffff};
  int bit_l [10] = '{2, 3, 8, 11, 14, 16, 13, 20, 21, 22};
  int bad_count = 0;
  int comparisons = 0;
  always #20 clk_i = ~clk_i;
  pin_board_model i_board (.strap_i(strap), .boot_mode_pins_o(boot_mode_pins_i),
    .dir_p1_o(port_direction_register_p1_i), .dir_p2_o(port_direction_register_p2_i),
    .dir_p3_o(port_direction_register_p3_i));
  bus_pin_function_select i_dut (.*);
  function automatic logic [31:0] pins();
    return {16'h0, debug_port_en_o, trace_port_en_o, chip_select_zero_en_o, output_enable_en_o,
      byte_lane_zero_en_o, byte_lane_one_en_o, byte_lane_two_en_o, byte_lane_three_en_o,
      write_enable_en_o, chip_select_one_en_o, chip_select_two_en_o, chip_select_three_en_o,
      clock_output_pin_en_o, p2_hi_reserved_en_o, analog_input_four_en_o, analog_input_five_en_o};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Holds the request until the edge that samples the answer
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'h3, w, bsel, a, d};
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    got_err = err_o;
    {cyc_i, stb_i} <= 2'h0;
  endtask
  // Pins follow the register one edge after the write
  task automatic put(input logic [31:0] d);
    wb(1'b1, reg_a, d);
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_straps();
    for (int s = 0; s < 4; s++)
    begin
      strap <= s[1:0];
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, reg_a, 32'h0);
      chk(rd, {4'h0, (s == 3) ? 3'h0 : 3'h7, s[1], s == 0, 23'h600000});
      chk({8'h0, upper_address_lines_en_o},
        {8'h0, (s == 3) ? 22'h0 : 22'h3fffff, s[1], s == 0});
      chk(pins(), 32'h3803);
    end
  endtask
  task automatic t_regs();
    put(32'hf00016c3);
    wb(1'b0, reg_a, 32'h0);
    chk(rd, 32'h0);
    chk(pins(), 32'h3800);
    for (int f = 0; f < 4; f++)
    begin
      put(f << 4);
      chk(data_lane_en_o, lane_x[f]);
      chk(pins(), pin_x[f]);
      chk(p2_dir_o, (f == 3) ? 32'hffffffff : ~lane_x[f]);
    end
    put(32'h00600020);
    chk(pins(), 32'h3f00);
    for (int i = 0; i < 10; i++)
    begin
      put((32'h1 << bit_l[i]) | 32'h30);
      chk(pins(), 32'h1 << ((i < 2) ? 15 - i : 9 - i));
    end
    for (int c = 0; c < 8; c++)
    begin
      put({4'h0, c[2:0], 25'h1802030});
      chk({8'h0, upper_address_lines_en_o}, {8'h0, am[c], 2'h3});
      chk(pins(), (c != 7) ? 32'h8 : 32'h0);
    end
  endtask
  task automatic t_dir_err();
    put(32'h3c);
    chk(p1_dir_o, 32'h03ffffff);
    put(32'h0);
    chk(p3_dir_o, 32'hd555aaaa);
    wb(1'b0, reg_a + 32'h4, 32'h0);
    chk({31'h0, got_err}, 32'h1);
  endtask
  // Only the selected byte lane may change
  task automatic t_sel();
    bsel = 4'h2;
    put(32'hffff69ff);
    bsel = 4'hf;
    wb(1'b0, reg_a, 32'h0);
    chk(rd, 32'h00006900);
    chk(pins(), 32'h38e8);
    chk(p3_dir_o, 32'hdfd5aaaa);
  endtask
  initial
  begin
    t_straps();
    t_regs();
    t_dir_err();
    t_sel();
    end_sim();
  end
  initial
  begin
    #400000;
    bad_count++;
    end_sim();
  end
endmodule // bus_pin_function_select_tb_top

// ==== testbench/pin_board_model.sv ====
/* Board model: boot straps and GPIO direction bits.
   Assumes the bench picks the strap value. */
`timescale 1ns/1ps
module pin_board_model
(
  // Strap choice
  input wire logic [1:0] strap_i,
  // Pins to the block
  output logic [1:0] boot_mode_pins_o,
  output logic [31:0] dir_p1_o,
  output logic [31:0] dir_p2_o,
  output logic [31:0] dir_p3_o
);
  // Straps held steady, as resistors would
  assign boot_mode_pins_o = strap_i;
  // Mostly outputs, so forced inputs stand out
  assign dir_p1_o = 32'hffffffff;
  assign dir_p2_o = 32'hffffffff;
  assign dir_p3_o = 32'h5555aaaa;
endmodule // pin_board_model

// ==== testbench/pin_select_checker.sv ====
/* Port checker for the bus pin function select block.
   Assumes it is bound to the design top below. */
`timescale 1ns/1ps
module pin_select_checker
(
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [31:0] data_lane_en_o,
  input wire logic chip_select_zero_en_o,
  input wire logic byte_lane_one_en_o,
  input wire logic byte_lane_two_en_o,
  input wire logic trace_port_en_o,
  input wire logic [31:0] port_direction_register_p1_i,
  input wire logic [31:0] p1_dir_o,
  input wire logic clock_output_pin_en_o,
  input wire logic [23:0] upper_address_lines_en_o,
  input wire logic analog_input_four_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_answer;
    ##[1:2] (ack_o || err_o);
  endsequence
  // Two cycles only right after reset
  a_bus_answer: assert property (s_req |-> s_answer) else $error("no bus answer");
  a_cs0_narrow: assert property (chip_select_zero_en_o == &data_lane_en_o[7:0])
    else $error("cs0 and low lanes differ");
  a_half_lane: assert property (byte_lane_one_en_o == &data_lane_en_o[15:8])
    else $error("lane one and mid lanes differ");
  a_wide_lane: assert property (byte_lane_two_en_o == &data_lane_en_o[31:16])
    else $error("lane two and high lanes differ");
  a_wide_analog: assert property (byte_lane_two_en_o |-> !analog_input_four_en_o)
    else $error("analog input on wide bus");
  a_clk_count: assert property (clock_output_pin_en_o |-> !upper_address_lines_en_o[23])
    else $error("clock out with full address");
  a_addr_therm: assert property ((upper_address_lines_en_o[23:2]
    & (upper_address_lines_en_o[23:2] + 22'h1)) == 22'h0) else $error("address lines gap");
  a_gpio_dir: assert property (!trace_port_en_o && $stable(trace_port_en_o)
    && !$past(rst_i, 2) |-> p1_dir_o[25:16] == $past(port_direction_register_p1_i[25:16]))
    else $error("gpio direction not applied");
endmodule // pin_select_checker
bind bus_pin_function_select pin_select_checker i_chk (.*);
